// ### acd_reg_bank.v
`timescale 1ns/1ns
`default_nettype none
`include "acd_consts.vh"
// What this block does
// R1 - mirrored bit selects msb or lsb first
// R2 - default restore keeps port and multiplier registers
// R3 - read-only grade field, zero means widest
// R4 - two-bit power state, resets to normal
// R5 - multiplier enable, autoband and ratio, zero default
// R6 - lock status readable in multiplier register
// R7 - interleave merges both channels on bus
// R8 - tristate bit floats data outputs
// R9 - invert bit flips every data bit
// R10 - two drive fields, low supply resets two
// R11 - external reference select, default internal
// R12 - six-bit output rate field, zero default
// R13 - top bit routes loop reset to overrange
// R14 - coding: offset, twos complement, gray, offset
// R15 - bandwidth codes select 10, 5, 2.5, 10
// R16 - threshold mode compares raw channel A sample against threshold
// R17 - every register readable serially, writable except ID and grade
module acd_reg_bank #(
  parameter [7:0] DEVICE_IDENTIFIER = `ACD_DEVICE_IDENTIFIER_DEFAULT // arbitrary value
) (
  input wire i_clk,
  input wire i_nrst,
  input wire i_sclk,
  input wire i_chip_select_n,
  input wire i_sdio,
  output wire o_sdio,
  output wire o_sdio_oe,
  input wire i_multiplier_locked,
  input wire [15:0] i_sample_a,
  input wire [15:0] i_sample_b,
  input wire i_sample_valid,
  input wire i_analog_trip,
  input wire i_loop_reset,
  output wire [15:0] o_data,
  output wire o_data_oe,
  output wire o_data_valid,
  output wire o_overrange,
  output wire [1:0] o_power_state_select,
  output wire o_clock_multiplier_enable,
  output wire o_multiplier_autoband,
  output wire [5:0] o_multiplier_ratio,
  output wire [1:0] o_bandwidth_select,
  output wire o_output_voltage_standard,
  output wire [1:0] o_drive_strength_high_supply,
  output wire [1:0] o_drive_strength_low_supply,
  output wire o_data_clock_invert,
  output wire o_external_voltage_ref_select,
  output wire [5:0] o_output_rate_select
);
  ////////////////////////////////////////////////////////////////////////
  // serial engine state
  reg sclk_d_reg;
  reg in_data_reg;
  reg rw_reg;
  reg [3:0] cnt_reg;
  reg [15:0] shift_reg;
  reg [12:0] addr_reg;
  reg sdio_out_reg;
  reg sdio_oe_reg;
  reg wr_pulse_reg;
  reg [12:0] wr_addr_reg;
  reg [7:0] wr_data_reg;
  reg restore_reg;
  // register fields
  reg bit_order_select_reg;
  reg [1:0] power_state_select_reg;
  reg clock_multiplier_enable_reg;
  reg multiplier_autoband_reg;
  reg [5:0] multiplier_ratio_reg;
  reg multiplier_lock_flag_reg;
  reg [1:0] bandwidth_select_reg;
  reg output_voltage_standard_reg;
  reg interleave_reg;
  reg output_tristate_reg;
  reg output_bit_invert_reg;
  reg [1:0] coding_reg;
  reg [1:0] drive_high_reg;
  reg [1:0] drive_low_reg;
  reg data_clock_invert_reg;
  reg ext_ref_reg;
  reg [5:0] output_rate_reg;
  reg lf_reset_enable_reg;
  reg overrange_mode_reg;
  reg [5:0] overrange_threshold_reg;
  // combinational helpers
  wire sclk_rise;
  wire sclk_fall;
  wire [15:0] shift_next;
  wire [7:0] byte_in;
  wire [2:0] tx_index;
  reg [7:0] read_data;

  ////////////////////////////////////////////////////////////////////////
  // edges of the shift clock, sampled on the core clock
  assign sclk_rise = i_sclk & ~sclk_d_reg;
  assign sclk_fall = ~i_sclk & sclk_d_reg;
  // msb first shifts left, lsb first shifts right
  assign shift_next = bit_order_select_reg ?
    {i_sdio, shift_reg[15:1]} : {shift_reg[14:0], i_sdio}; // R1
  assign byte_in = bit_order_select_reg ?
    shift_next[15:8] : shift_next[7:0]; // R1
  assign tx_index = bit_order_select_reg ?
    cnt_reg[2:0] : 3'h7 - cnt_reg[2:0]; // R1

  ////////////////////////////////////////////////////////////////////////
  // frame handling: 16-bit instruction, then streamed bytes
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sclk_d_reg <= 1'b0;
      in_data_reg <= 1'b0;
      rw_reg <= 1'b0;
      cnt_reg <= 4'h0;
      shift_reg <= 16'h0000;
      addr_reg <= 13'h0000;
      sdio_out_reg <= 1'b0;
      sdio_oe_reg <= 1'b0;
      wr_pulse_reg <= 1'b0;
      wr_addr_reg <= 13'h0000;
      wr_data_reg <= 8'h00;
    end else begin
      sclk_d_reg <= i_sclk;
      wr_pulse_reg <= 1'b0;
      if (i_chip_select_n) begin
        // deselect aborts the frame and releases the data pin
        in_data_reg <= 1'b0;
        cnt_reg <= 4'h0;
        sdio_oe_reg <= 1'b0;
      end else if (sclk_rise) begin
        shift_reg <= shift_next;
        if (!in_data_reg) begin
          if (cnt_reg == `ACD_INSTR_LAST) begin
            in_data_reg <= 1'b1;
            cnt_reg <= 4'h0;
            rw_reg <= shift_next[15];
            addr_reg <= shift_next[12:0];
          end else begin
            cnt_reg <= cnt_reg + 4'h1;
          end
        end else if (cnt_reg == `ACD_BYTE_LAST) begin
          cnt_reg <= 4'h0;
          addr_reg <= addr_reg + 13'h0001;
          if (!rw_reg) begin
            wr_pulse_reg <= 1'b1; // R17
            wr_addr_reg <= addr_reg;
            wr_data_reg <= byte_in;
          end
        end else begin
          cnt_reg <= cnt_reg + 4'h1;
        end
      end else if (sclk_fall && in_data_reg && rw_reg) begin
        // read data changes on the falling edge
        sdio_oe_reg <= 1'b1;
        sdio_out_reg <= read_data[tx_index]; // R17
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // readback multiplexer, unmapped addresses read zero
  always @* begin
    case (addr_reg)
      `ACD_ADDR_PORT: read_data = {1'b0, bit_order_select_reg, 1'b0,
        2'b11, 1'b0, bit_order_select_reg, 1'b0}; // R1
      `ACD_ADDR_ID: read_data = DEVICE_IDENTIFIER;
      `ACD_ADDR_GRADE: read_data = {2'b00, `ACD_GRADE_CODE, 4'h0}; // R3
      `ACD_ADDR_POWER: read_data = {6'h00, power_state_select_reg};
      `ACD_ADDR_MULT_EN:
        read_data = {5'h00, clock_multiplier_enable_reg, 2'b00};
      `ACD_ADDR_MULT: read_data = {multiplier_lock_flag_reg,
        multiplier_autoband_reg, multiplier_ratio_reg}; // R6
      `ACD_ADDR_BW: read_data = {1'b0, bandwidth_select_reg, 5'h00};
      `ACD_ADDR_OUT_FMT: read_data = {output_voltage_standard_reg, 1'b0,
        interleave_reg, output_tristate_reg, 1'b0,
        output_bit_invert_reg, coding_reg}; // R9
      `ACD_ADDR_DRIVE: read_data = {4'h0, drive_high_reg, drive_low_reg};
      `ACD_ADDR_DCLK: read_data = {data_clock_invert_reg, 7'h00};
      `ACD_ADDR_REF: read_data = {1'b0, ext_ref_reg, 6'h00};
      `ACD_ADDR_RATE: read_data = {2'b00, output_rate_reg};
      `ACD_ADDR_OVR: read_data = {lf_reset_enable_reg,
        overrange_mode_reg, overrange_threshold_reg};
      default: read_data = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // registers kept through a default restore
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      bit_order_select_reg <= 1'b0;
      clock_multiplier_enable_reg <= 1'b0;
      multiplier_autoband_reg <= 1'b0;
      multiplier_ratio_reg <= 6'h00;
      multiplier_lock_flag_reg <= 1'b0;
      restore_reg <= 1'b0;
    end else begin
      // lock only reported while the multiplier runs
      multiplier_lock_flag_reg <=
        clock_multiplier_enable_reg & i_multiplier_locked; // R6
      restore_reg <= 1'b0;
      if (wr_pulse_reg) begin
        case (wr_addr_reg)
          `ACD_ADDR_PORT: begin
            bit_order_select_reg <= wr_data_reg[`ACD_BIT_ORDER_HI] |
              wr_data_reg[`ACD_BIT_ORDER_LO]; // R1
            restore_reg <= wr_data_reg[`ACD_DEF_RESTORE_HI] |
              wr_data_reg[`ACD_DEF_RESTORE_LO]; // R2
          end
          `ACD_ADDR_MULT_EN: clock_multiplier_enable_reg <=
            wr_data_reg[`ACD_MULT_EN_BIT]; // R5
          `ACD_ADDR_MULT: begin
            multiplier_autoband_reg <= wr_data_reg[`ACD_AUTOBAND_BIT]; // R5
            multiplier_ratio_reg <= wr_data_reg[5:0]; // R5
          end
          default: restore_reg <= 1'b0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers returned to defaults by reset or default restore
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      power_state_select_reg <= 2'h0; // R4
      bandwidth_select_reg <= 2'h0; // R15
      output_voltage_standard_reg <= 1'b0;
      interleave_reg <= 1'b0;
      output_tristate_reg <= 1'b0;
      output_bit_invert_reg <= 1'b0;
      coding_reg <= 2'h0;
      drive_high_reg <= 2'h0;
      drive_low_reg <= `ACD_DRIVE_LOW_RST; // R10
      data_clock_invert_reg <= 1'b0;
      ext_ref_reg <= 1'b0; // R11
      output_rate_reg <= 6'h00; // R12
      lf_reset_enable_reg <= 1'b0;
      overrange_mode_reg <= 1'b0;
      overrange_threshold_reg <= 6'h00;
    end else if (restore_reg) begin
      power_state_select_reg <= 2'h0; // R2 R4
      bandwidth_select_reg <= 2'h0;
      output_voltage_standard_reg <= 1'b0;
      interleave_reg <= 1'b0;
      output_tristate_reg <= 1'b0;
      output_bit_invert_reg <= 1'b0;
      coding_reg <= 2'h0;
      drive_high_reg <= 2'h0;
      drive_low_reg <= `ACD_DRIVE_LOW_RST; // R10
      data_clock_invert_reg <= 1'b0;
      ext_ref_reg <= 1'b0;
      output_rate_reg <= 6'h00;
      lf_reset_enable_reg <= 1'b0;
      overrange_mode_reg <= 1'b0;
      overrange_threshold_reg <= 6'h00;
    end else if (wr_pulse_reg) begin
      case (wr_addr_reg)
        `ACD_ADDR_POWER: power_state_select_reg <= wr_data_reg[1:0]; // R4
        `ACD_ADDR_BW: bandwidth_select_reg <= wr_data_reg[6:5]; // R15
        `ACD_ADDR_OUT_FMT: begin
          output_voltage_standard_reg <= wr_data_reg[`ACD_VSTD_BIT];
          interleave_reg <= wr_data_reg[`ACD_INTERLEAVE_BIT]; // R7
          output_tristate_reg <= wr_data_reg[`ACD_TRISTATE_BIT]; // R8
          output_bit_invert_reg <= wr_data_reg[`ACD_INVERT_BIT]; // R9
          coding_reg <= wr_data_reg[1:0]; // R14
        end
        `ACD_ADDR_DRIVE: begin
          drive_high_reg <= wr_data_reg[3:2]; // R10
          drive_low_reg <= wr_data_reg[1:0]; // R10
        end
        `ACD_ADDR_DCLK:
          data_clock_invert_reg <= wr_data_reg[`ACD_DCLK_INV_BIT];
        `ACD_ADDR_REF: ext_ref_reg <= wr_data_reg[`ACD_EXT_REF_BIT]; // R11
        `ACD_ADDR_RATE: output_rate_reg <= wr_data_reg[5:0]; // R12
        `ACD_ADDR_OVR: begin
          lf_reset_enable_reg <= wr_data_reg[`ACD_LF_RESET_BIT]; // R13
          overrange_mode_reg <= wr_data_reg[`ACD_OR_MODE_BIT];
          overrange_threshold_reg <= wr_data_reg[5:0]; // R16
        end
        default: output_rate_reg <= output_rate_reg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output data formatting
  acd_data_path u_data_path (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_sample_a(i_sample_a),
    .i_sample_b(i_sample_b),
    .i_sample_valid(i_sample_valid),
    .i_coding(coding_reg),
    .i_invert(output_bit_invert_reg),
    .i_tristate(output_tristate_reg),
    .i_interleave(interleave_reg),
    .o_data(o_data),
    .o_data_oe(o_data_oe),
    .o_data_valid(o_data_valid)
  );

  // overrange indication
  acd_overrange u_overrange (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_sample(i_sample_a),
    .i_sample_valid(i_sample_valid),
    .i_analog_trip(i_analog_trip),
    .i_loop_reset(i_loop_reset),
    .i_lf_reset_enable(lf_reset_enable_reg),
    .i_full_mode(overrange_mode_reg),
    .i_threshold(overrange_threshold_reg),
    .o_overrange(o_overrange)
  );

  ////////////////////////////////////////////////////////////////////////
  // serial pin and control outputs straight from their registers
  assign o_sdio = sdio_out_reg;
  assign o_sdio_oe = sdio_oe_reg;
  assign o_power_state_select = power_state_select_reg; // R4
  assign o_clock_multiplier_enable = clock_multiplier_enable_reg; // R5
  assign o_multiplier_autoband = multiplier_autoband_reg;
  assign o_multiplier_ratio = multiplier_ratio_reg;
  assign o_bandwidth_select = bandwidth_select_reg; // R15
  assign o_output_voltage_standard = output_voltage_standard_reg;
  assign o_drive_strength_high_supply = drive_high_reg;
  assign o_drive_strength_low_supply = drive_low_reg;
  assign o_data_clock_invert = data_clock_invert_reg;
  assign o_external_voltage_ref_select = ext_ref_reg; // R11
  assign o_output_rate_select = output_rate_reg; // R12
endmodule // acd_reg_bank
`default_nettype wire

// ### acd_consts.vh
`ifndef ACD_CONSTS_VH
`define ACD_CONSTS_VH
// register addresses, 13-bit serial address space
`define ACD_ADDR_PORT 13'h0000
`define ACD_ADDR_ID 13'h0001
`define ACD_ADDR_GRADE 13'h0002
`define ACD_ADDR_POWER 13'h0008
`define ACD_ADDR_MULT_EN 13'h0009
`define ACD_ADDR_MULT 13'h000a
`define ACD_ADDR_BW 13'h000f
`define ACD_ADDR_OUT_FMT 13'h0014
`define ACD_ADDR_DRIVE 13'h0015
`define ACD_ADDR_DCLK 13'h0016
`define ACD_ADDR_REF 13'h0018
`define ACD_ADDR_RATE 13'h0101
`define ACD_ADDR_OVR 13'h0111
// field positions
`define ACD_BIT_ORDER_HI 6
`define ACD_BIT_ORDER_LO 1
`define ACD_DEF_RESTORE_HI 5
`define ACD_DEF_RESTORE_LO 2
`define ACD_MULT_EN_BIT 2
`define ACD_LOCK_BIT 7
`define ACD_AUTOBAND_BIT 6
`define ACD_VSTD_BIT 7
`define ACD_INTERLEAVE_BIT 5
`define ACD_TRISTATE_BIT 4
`define ACD_INVERT_BIT 2
`define ACD_DCLK_INV_BIT 7
`define ACD_EXT_REF_BIT 6
`define ACD_LF_RESET_BIT 7
`define ACD_OR_MODE_BIT 6
// reset values
`define ACD_DRIVE_LOW_RST 2'h2
`define ACD_GRADE_CODE 2'h0
`define ACD_DEVICE_IDENTIFIER_DEFAULT 8'h5a
// serial framing counts
`define ACD_INSTR_LAST 4'hf
`define ACD_BYTE_LAST 4'h7
// overrange limits on offset-binary samples
`define ACD_DIGITAL_TRIP 16'h7fff
`define ACD_THRESH_FILL 10'h000
`endif

// ### acd_data_path.v
`timescale 1ns/1ns
`default_nettype none
`include "acd_consts.vh"
module acd_data_path (
  input wire i_clk,
  input wire i_nrst,
  input wire [15:0] i_sample_a,
  input wire [15:0] i_sample_b,
  input wire i_sample_valid,
  input wire [1:0] i_coding,
  input wire i_invert,
  input wire i_tristate,
  input wire i_interleave,
  output reg [15:0] o_data,
  output reg o_data_oe,
  output reg o_data_valid
);
  reg chan_b_reg;
  wire [15:0] pick;
  ////////////////////////////////////////////////////////////////////////
  // convert offset binary to the selected coding
  function [15:0] encode;
    input [15:0] s;
    input [1:0] c;
    begin
      case (c)
        2'h1: encode = {~s[15], s[14:0]};
        2'h2: encode = s ^ {1'b0, s[15:1]};
        default: encode = s;
      endcase
    end
  endfunction
  // channel choice alternates per sample when merged
  assign pick = (i_interleave && chan_b_reg) ? i_sample_b : i_sample_a; // R7
  ////////////////////////////////////////////////////////////////////////
  // output register with invert and tristate
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_data <= 16'h0000;
      o_data_oe <= 1'b0;
      o_data_valid <= 1'b0;
      chan_b_reg <= 1'b0;
    end else begin
      o_data_oe <= ~i_tristate; // R8
      o_data_valid <= i_sample_valid;
      if (i_sample_valid) begin
        chan_b_reg <= i_interleave & ~chan_b_reg; // R7
        if (i_invert) begin
          o_data <= ~encode(pick, i_coding); // R9 R14
        end else begin
          o_data <= encode(pick, i_coding); // R14
        end
      end
    end
  end
endmodule // acd_data_path
`default_nettype wire

// ### acd_overrange.v
`timescale 1ns/1ns
`default_nettype none
`include "acd_consts.vh"
module acd_overrange (
  input wire i_clk,
  input wire i_nrst,
  input wire [15:0] i_sample,
  input wire i_sample_valid,
  input wire i_analog_trip,
  input wire i_loop_reset,
  input wire i_lf_reset_enable,
  input wire i_full_mode,
  input wire [5:0] i_threshold,
  output reg o_overrange
);
  wire digital_trip;
  wire thresh_trip;
  reg level;
  // digital comparisons on the raw sample
  assign digital_trip = i_sample > `ACD_DIGITAL_TRIP;
  assign thresh_trip = i_sample > {i_threshold, `ACD_THRESH_FILL};
  ////////////////////////////////////////////////////////////////////////
  // mode select for the indicator
  always @* begin
    if (i_full_mode) begin
      level = i_analog_trip | digital_trip;
    end else if (i_threshold == 6'h00) begin
      level = digital_trip;
    end else begin
      level = thresh_trip; // R16
    end
  end
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_overrange <= 1'b0;
    end else if (i_lf_reset_enable && i_loop_reset) begin
      o_overrange <= 1'b1; // R13
    end else if (i_sample_valid) begin
      o_overrange <= level; // R16
    end
  end
endmodule // acd_overrange
`default_nettype wire

// ### acd_reg_bank_properties.sv
`timescale 1ns/1ns
`default_nettype none
module acd_reg_bank_chk (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_sclk,
  input wire logic i_chip_select_n,
  input wire logic i_sample_valid,
  input wire logic i_loop_reset,
  input wire logic o_sdio,
  input wire logic o_sdio_oe,
  input wire logic [15:0] o_data,
  input wire logic o_data_oe,
  input wire logic o_data_valid,
  input wire logic o_overrange,
  input wire logic [1:0] o_power_state_select,
  input wire logic [1:0] o_drive_strength_low_supply,
  input wire logic [5:0] o_output_rate_select
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // first edge out of reset
  sequence rel;
    $rose(i_nrst);
  endsequence
  // select idle long enough for a write to land
  sequence quiet_sel;
    i_chip_select_n [*4];
  endsequence
  //////////////////////////////
  valid_delay_a: assert property (o_data_valid == $past(i_sample_valid))
    else $error("data valid not one cycle after sample valid");
  data_hold_a: assert property (!i_sample_valid |=> $stable(o_data))
    else $error("data word moved without a sample");
  oe_release_a: assert property (rel |=> o_data_oe)
    else $error("data bus not driven after reset");
  reset_dflt_a: assert property (rel |-> o_power_state_select == 2'h0
    && o_drive_strength_low_supply == 2'h2)
    else $error("field defaults wrong after reset");
  fields_quiet_a: assert property (quiet_sel |=>
    $stable(o_power_state_select) && $stable(o_output_rate_select))
    else $error("field changed with select idle");
  sdio_release_a: assert property (i_chip_select_n [*2] |-> !o_sdio_oe)
    else $error("serial line driven while deselected");
  sdio_timing_a: assert property (o_sdio_oe && !$stable(o_sdio) |->
    !$past(i_sclk) && $past(i_sclk, 2))
    else $error("read bit moved off a shift clock fall");
  ovr_cause_a: assert property ($rose(o_overrange) |->
    $past(i_sample_valid) || $past(i_loop_reset))
    else $error("overrange rose without cause");
endmodule // acd_reg_bank_chk
bind acd_reg_bank acd_reg_bank_chk chk_u (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_sclk(i_sclk),
  .i_chip_select_n(i_chip_select_n), .i_sample_valid(i_sample_valid),
  .i_loop_reset(i_loop_reset), .o_sdio(o_sdio), .o_sdio_oe(o_sdio_oe),
  .o_data(o_data), .o_data_oe(o_data_oe), .o_data_valid(o_data_valid),
  .o_overrange(o_overrange), .o_power_state_select(o_power_state_select),
  .o_drive_strength_low_supply(o_drive_strength_low_supply),
  .o_output_rate_select(o_output_rate_select));
`default_nettype wire

// ### acd_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module acd_host_model (
  input wire logic i_clk,
  input wire logic i_dev_sdio,
  input wire logic i_dev_sdio_oe,
  output logic o_sclk,
  output logic o_chip_select_n,
  output logic o_sdio
);
  logic drv_en = 1'b0;
  logic drv_bit = 1'b0;
  logic noise = 1'b0;
  logic lsb = 1'b0;
  int half = 3;
  initial o_sclk = 1'b0;
  initial o_chip_select_n = 1'b1;
  // released line toggles, never keeps the last bit
  always @(posedge i_clk) noise <= ~noise;
  assign o_sdio = i_dev_sdio_oe ? i_dev_sdio : (drv_en ? drv_bit : noise);
  //////////////////////////////
  // one shift clock period, read bit taken at the rise
  task automatic shift(input logic b, output logic r);
    drv_bit = b;
    repeat (half) @(negedge i_clk);
    r = o_sdio;
    o_sclk = 1'b1;
    repeat (half) @(negedge i_clk);
    o_sclk = 1'b0;
  endtask
  // instruction plus one data byte in the chosen bit order
  task automatic access(input logic rd, input logic [12:0] adr,
      input logic [7:0] wd, output logic [7:0] rdv);
    logic [23:0] w;
    logic r;
    int k;
    w = {rd, 2'b00, adr, wd};
    o_chip_select_n = 1'b0;
    drv_en = 1'b1;
    for (int i = 0; i < 24; i++) begin
      if (i == 16 && rd) drv_en = 1'b0;
      k = lsb ? (i < 16 ? i + 8 : i - 16) : 23 - i;
      shift(w[k], r);
      if (i >= 16) rdv[k] = r;
    end
    repeat (half) @(negedge i_clk);
    o_chip_select_n = 1'b1;
    drv_en = 1'b0;
    repeat (3) @(negedge i_clk);
  endtask
endmodule // acd_host_model
`default_nettype wire

// ### test_acd_reg_bank.sv
`timescale 1ns/1ns
`default_nettype none
module test_acd_reg_bank;
  localparam logic [7:0] ID = 8'h3c; // arbitrary identifier value
  localparam logic [12:0] ADR [10] = '{13'h008, 13'h009, 13'h00a,
    13'h00f, 13'h014, 13'h015, 13'h016, 13'h018, 13'h101, 13'h111};
  localparam logic [7:0] MSK [10] = '{8'h03, 8'h04, 8'h7f, 8'h60,
    8'hb7, 8'h0f, 8'h80, 8'h40, 8'h3f, 8'hff};
  localparam logic [5:0] TH [3] = '{6'h00, 6'h20, 6'h3f};
  logic clk, nrst, sclk, csn, sdi, sdo, soe, lock, sv, trip, lres, pick;
  logic doe, dval, ovr, en, au, vstd, dinv, eref;
  logic [15:0] sa, sb, dat, s;
  logic [1:0] pwr, bw, dh, dl;
  logic [5:0] ratio, rate;
  logic [7:0] rv, e;
  logic [7:0] wv [10];
  logic [31:0] exp_q [$];
  logic [31:0] seen_v;
  string seen_n;
  event seen_ev;
  int errors = 0;
  int check_count = 0;
  wire logic [24:0] fld = {pwr, en, au, ratio, bw, vstd, dh, dl, dinv,
    eref, rate};
  acd_reg_bank #(.DEVICE_IDENTIFIER(ID)) dut_u (.i_clk(clk), .i_nrst(nrst),
    .i_sclk(sclk), .i_chip_select_n(csn), .i_sdio(sdi), .o_sdio(sdo),
    .o_sdio_oe(soe), .i_multiplier_locked(lock), .i_sample_a(sa),
    .i_sample_b(sb), .i_sample_valid(sv), .i_analog_trip(trip),
    .i_loop_reset(lres), .o_data(dat), .o_data_oe(doe),
    .o_data_valid(dval), .o_overrange(ovr), .o_power_state_select(pwr),
    .o_clock_multiplier_enable(en), .o_multiplier_autoband(au),
    .o_multiplier_ratio(ratio), .o_bandwidth_select(bw),
    .o_output_voltage_standard(vstd), .o_drive_strength_high_supply(dh),
    .o_drive_strength_low_supply(dl), .o_data_clock_invert(dinv),
    .o_external_voltage_ref_select(eref), .o_output_rate_select(rate));
  acd_host_model host_u (.i_clk(clk), .i_dev_sdio(sdo),
    .i_dev_sdio_oe(soe), .o_sclk(sclk), .o_chip_select_n(csn),
    .o_sdio(sdi));
  // clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  //////////////////////////////
  task automatic check(input string n, input logic [31:0] sn,
      input logic [31:0] ex);
    check_count++;
    if (sn !== ex) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, ex, sn);
    end
  endtask
  // oldest note against what appeared
  task automatic take(input string n, input logic [31:0] v);
    if (exp_q.size() == 0) check(n, v, ~v);
    else check(n, v, exp_q.pop_front());
  endtask
  // monitors
  always @(negedge clk) if (dval === 1'b1) take("data", {15'h0, doe, dat});
  always @(seen_ev) take(seen_n, seen_v);
  task automatic see(input string n, input logic [31:0] v);
    seen_n = n;
    seen_v = v;
    ->seen_ev;
    @(negedge clk);
  endtask
  function automatic logic [24:0] fexp();
    return {wv[0][1:0], wv[1][2], wv[2][6], wv[2][5:0], wv[3][6:5],
      wv[4][7], wv[5][3:2], wv[5][1:0], wv[6][7], wv[7][6], wv[8][5:0]};
  endfunction
  task automatic chk_fld();
    exp_q.push_back({7'h0, fexp()});
    see("fields", {7'h0, fld});
  endtask
  function automatic logic [15:0] code(input logic [15:0] x);
    logic [15:0] c;
    c = wv[4][1:0] == 2'h1 ? x ^ 16'h8000 :
      wv[4][1:0] == 2'h2 ? x ^ (x >> 1) : x;
    return wv[4][2] ? ~c : c;
  endfunction
  // one sample held valid; caller drops valid
  task automatic sample(input logic [15:0] a, input logic [15:0] b);
    exp_q.push_back({15'h0, ~wv[4][4], code(pick ? b : a)});
    sa = a;
    sb = b;
    sv = 1'b1;
    @(negedge clk);
    if (wv[4][5]) pick = ~pick;
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    host_u.access(1'b0, a, d, rv);
  endtask
  task automatic rd_chk(input logic [12:0] a, input logic [7:0] x);
    exp_q.push_back({24'h0, x});
    host_u.access(1'b1, a, 8'h00, rv);
    see("reg", {24'h0, rv});
  endtask
  task automatic ovr_chk(input logic x);
    sv = 1'b0;
    @(negedge clk);
    exp_q.push_back({31'h0, x});
    see("ovr", {31'h0, ovr});
  endtask
  task automatic summarize();
    if (errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // watchdog
  initial begin
    #500000;
    errors++;
    summarize();
  end
  //////////////////////////////
  initial begin
    nrst = 1'b0;
    {sv, trip, lres, lock, pick, sa, sb} = '0;
    void'($urandom(23218));
    foreach (wv[i]) wv[i] = 8'h00;
    wv[5] = 8'h02;
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    chk_fld();
    rd_chk(13'h000, 8'h18);
    rd_chk(13'h001, ID);
    wr(13'h002, 8'hff);
    rd_chk(13'h002, 8'h00);
    wr(13'h003, 8'h5a);
    rd_chk(13'h003, 8'h00);
    lock = 1'b1;
    for (int i = 0; i < 10; i++) begin
      wv[i] = 8'($urandom) & MSK[i];
      wr(ADR[i], wv[i]);
      e = wv[i];
      if (i == 2) e[7] = wv[1][2];
      rd_chk(ADR[i], e);
    end
    chk_fld();
    host_u.half = 5;
    for (int c = 0; c < 4; c++) begin
      wv[0] = 8'(c);
      wv[3] = 8'(c << 5);
      wr(13'h008, wv[0]);
      wr(13'h00f, wv[3]);
      chk_fld();
    end
    host_u.half = 3;
    for (int m = 0; m < 16; m++) begin
      wv[4] = {2'b00, m[3], m == 5, 1'b0, m[2], m[1:0]};
      wr(13'h014, wv[4]);
      pick = 1'b0;
      repeat (4) sample(16'($urandom), 16'($urandom));
      sv = 1'b0;
    end
    for (int k = 0; k < 6; k++) begin
      wv[9] = {2'b00, TH[k / 2]};
      wr(13'h111, wv[9]);
      s = (k < 2 ? 16'h7fff : {TH[k / 2], 10'h000}) + 16'(k % 2);
      sample(s, s);
      ovr_chk(k % 2);
    end
    lres = 1'b1;
    wr(13'h111, 8'h00);
    sample(16'h0000, 16'h0000);
    ovr_chk(1'b0);
    wr(13'h111, 8'h80);
    ovr_chk(1'b1);
    lres = 1'b0;
    wr(13'h111, 8'h40);
    sample(16'h0000, 16'h0000);
    ovr_chk(1'b0);
    trip = 1'b1;
    sample(16'h0000, 16'h0000);
    ovr_chk(1'b1);
    trip = 1'b0;
    wr(13'h000, 8'h42);
    host_u.lsb = 1'b1;
    rd_chk(13'h000, 8'h5a);
    wr(13'h000, 8'h66);
    foreach (wv[i]) if (i != 1 && i != 2) wv[i] = 8'h00;
    wv[5] = 8'h02;
    chk_fld();
    rd_chk(13'h000, 8'h5a);
    wr(13'h000, 8'h00);
    host_u.lsb = 1'b0;
    rd_chk(13'h000, 8'h18);
    summarize();
  end
endmodule // test_acd_reg_bank
`default_nettype wire
